// [rtl/drive_param_consts.svh]
`ifndef DRIVE_PARAM_CONSTS_SVH
`define DRIVE_PARAM_CONSTS_SVH

// time base
`define CLK_PERIOD_NS 8
`define MS_NS 1000000
`define CYCLES_PER_MS (`MS_NS / `CLK_PERIOD_NS)

// parameter numbers carried in the id word
`define PNUM_ABORT_TIME 11'h04A
`define PNUM_STARTUP_TORQUE 11'h04C
`define PNUM_END_HOLD 11'h04E
`define PNUM_REVERSAL_IDLE 11'h050
`define PNUM_BRAKE_HOLD 11'h054
`define PNUM_VOLT_AVERAGING 11'h056
`define PNUM_GP_FIRST 11'h058
`define PNUM_GP_LAST 11'h06A
`define PNUM_SUPPLY_THRESHOLD 11'h06C
`define PNUM_TEMP_LIMIT 11'h06E
`define PNUM_COMMAND 11'h071

// storage slots
`define SLOT_COUNT 18
`define SLOT_ABORT_TIME 5'h00
`define SLOT_STARTUP_TORQUE 5'h01
`define SLOT_END_HOLD 5'h02
`define SLOT_REVERSAL_IDLE 5'h03
`define SLOT_BRAKE_HOLD 5'h04
`define SLOT_VOLT_AVERAGING 5'h05
`define SLOT_GP_FIRST 5'h06
`define SLOT_GP_LAST 5'h0F
`define SLOT_SUPPLY_THRESHOLD 5'h10
`define SLOT_TEMP_LIMIT 5'h11
`define SLOT_NONE 5'h1F

// delivery values
`define RST_ABORT_TIME 32'h0000_00C8
`define RST_STARTUP_TORQUE 32'h0000_00C8
`define RST_END_HOLD 32'h0000_00C8
`define RST_REVERSAL_IDLE 32'h0000_000A
`define RST_BRAKE_HOLD 32'h0000_03E8
`define RST_VOLT_AVERAGING 32'h0000_0064
`define RST_GP 32'h0000_0000
`define RST_SUPPLY_THRESHOLD 32'h0000_00B9
`define RST_TEMP_LIMIT 32'h0000_0046

// permitted write ranges
`define MIN_ABORT_TIME 32'h0000_0032
`define MAX_ABORT_TIME 32'h0000_01F4
`define MIN_STARTUP_TORQUE 32'h0000_000A
`define MAX_STARTUP_TORQUE 32'h0000_03E8
`define MIN_END_HOLD 32'h0000_0000
`define MAX_END_HOLD 32'h0000_03E8
`define MIN_REVERSAL_IDLE 32'h0000_000A
`define MAX_REVERSAL_IDLE 32'h0000_2710
`define MIN_BRAKE_HOLD 32'h0000_0000
`define MAX_BRAKE_HOLD 32'h0000_0BB8
`define MIN_VOLT_AVERAGING 32'h0000_0064
`define MAX_VOLT_AVERAGING 32'h0000_03E8
`define MIN_SUPPLY_THRESHOLD 32'h0000_00B4
`define MAX_SUPPLY_THRESHOLD 32'h0000_00F0
`define MIN_TEMP_LIMIT 32'h0000_000A
`define MAX_TEMP_LIMIT 32'h0000_0046

// running supply floor, 0.1 V units
`define RUN_SUPPLY_FLOOR 16'h00AF

// id word layout and codes
`define ID_CODE_HI 15
`define ID_CODE_LO 12
`define ID_PNUM_HI 10
`define REQ_READ 4'h1
`define REQ_WRITE 4'h2
`define RESP_OK 4'h4
`define RESP_ERR 4'h7

// command values, 16 bit two's complement
`define CMD_FACTORY_SAVE 16'hFFFD
`define CMD_USER_RELOAD 16'hFFFE
`define CMD_FACTORY_NOSAVE 16'hFFFF
`define CMD_SAVE 16'h0001

// command status as read back
`define STAT_OK 16'h0000
`define STAT_BUSY 16'h0001
`define STAT_FAILED 16'h0002

`endif

// [rtl/drive_param_pkg.sv]
package drive_param_pkg;

  typedef enum logic [1:0] {
    CMD_IDLE = 2'b01,
    CMD_SAVING = 2'b10
  } cmd_state_type;

endpackage

// [rtl/ms_countdown.sv]
`timescale 1ns/1ps
`default_nettype none
`include "drive_param_consts.svh"

module ms_countdown #(
  parameter int CYCLES_PER_MS = `CYCLES_PER_MS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // control
  input wire logic start,
  input wire logic [15:0] period_ms,
  // status
  output logic active_q
);

  localparam int PW = $clog2(CYCLES_PER_MS + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(CYCLES_PER_MS - 1);

  logic [PW-1:0] pre_q, pre_d;
  logic [15:0] remain_q, remain_d;
  logic active_d;

  // a new start restarts the period, even mid-count
  always_comb begin
    pre_d = pre_q;
    remain_d = remain_q;
    active_d = active_q;
    if (start) begin
      pre_d = '0;
      remain_d = period_ms;
      active_d = (period_ms != 16'h0000);
    end else if (active_q) begin
      if (pre_q == PRE_LAST) begin
        pre_d = '0;
        remain_d = remain_q - 16'h0001;
        if (remain_q == 16'h0001) begin
          active_d = 1'b0;
        end
      end else begin
        pre_d = pre_q + PW'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pre_q <= '0;
      remain_q <= 16'h0000;
      active_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      remain_q <= remain_d;
      active_q <= active_d;
    end
  end

endmodule
`default_nettype wire

// [rtl/supply_averager.sv]
`timescale 1ns/1ps
`default_nettype none
`include "drive_param_consts.svh"

module supply_averager #(
  parameter int CYCLES_PER_MS = `CYCLES_PER_MS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // measurement and threshold in 0.1 V units, window in ms
  input wire logic [15:0] supply_sample,
  input wire logic [15:0] window_ms,
  input wire logic [15:0] threshold,
  // results
  output logic above_threshold_q,
  output logic above_run_floor_q
);

  localparam int PW = $clog2(CYCLES_PER_MS + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(CYCLES_PER_MS - 1);

  logic [PW-1:0] pre_q, pre_d;
  logic [15:0] cnt_q, cnt_d;
  logic [31:0] sum_q, sum_d;
  logic above_threshold_d, above_run_floor_d;
  logic [31:0] total;

  // sums are compared against limit times window, which avoids a divider
  always_comb begin
    pre_d = pre_q;
    cnt_d = cnt_q;
    sum_d = sum_q;
    above_threshold_d = above_threshold_q;
    above_run_floor_d = above_run_floor_q;
    total = sum_q + {16'h0000, supply_sample};
    if (pre_q == PRE_LAST) begin
      pre_d = '0;
      if (cnt_q + 16'h0001 >= window_ms) begin
        above_threshold_d = total > (threshold * window_ms);
        above_run_floor_d = total > (`RUN_SUPPLY_FLOOR * window_ms);
        cnt_d = 16'h0000;
        sum_d = 32'h0000_0000;
      end else begin
        cnt_d = cnt_q + 16'h0001;
        sum_d = total;
      end
    end else begin
      pre_d = pre_q + PW'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pre_q <= '0;
      cnt_q <= 16'h0000;
      sum_q <= 32'h0000_0000;
      above_threshold_q <= 1'b0;
      above_run_floor_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      sum_q <= sum_d;
      above_threshold_q <= above_threshold_d;
      above_run_floor_q <= above_run_floor_d;
    end
  end

endmodule
`default_nettype wire

// [rtl/drive_timing_param_store.sv]
`timescale 1ns/1ps
`default_nettype none
`include "drive_param_consts.svh"

module drive_timing_param_store #(
  parameter int CYCLES_PER_MS = `CYCLES_PER_MS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // parameter exchange, request side
  input wire logic param_if_enable,
  input wire logic param_req_valid,
  input wire logic [15:0] parameter_id_word,
  input wire logic [15:0] parameter_index_word,
  input wire logic [31:0] parameter_value_word,
  // parameter exchange, answer side
  output logic param_ack_q,
  output logic [15:0] ack_id_word_q,
  output logic [15:0] ack_index_word_q,
  output logic [31:0] ack_value_word_q,
  // drive state
  input wire logic standstill,
  input wire logic run_active,
  input wire logic run_start,
  input wire logic run_end,
  input wire logic dir_reverse,
  input wire logic [15:0] supply_sample,
  input wire logic [15:0] temperature_c,
  // drive controls
  output logic startup_torque_on_q,
  output logic end_hold_torque_on_q,
  output logic reversal_idle_on_q,
  output logic brake_released_q,
  output logic motor_power_present_q,
  output logic run_permit_q,
  output logic over_temp_q,
  output logic [15:0] abort_time_ms_q,
  // non-volatile store
  input wire logic nvm_boot_corrupt,
  input wire logic nvm_done,
  input wire logic nvm_fail,
  input wire logic [4:0] nvm_rd_slot,
  output logic nvm_save_req_q,
  output logic [31:0] nvm_rd_data_q,
  // network address control
  output logic addr_clear_q,
  output logic dynamic_addr_select_q
);

  function automatic logic [4:0] slot_of(input logic [10:0] pnum);
    logic [10:0] gp_off;
    gp_off = pnum - `PNUM_GP_FIRST;
    slot_of = `SLOT_NONE;
    if (pnum >= `PNUM_GP_FIRST && pnum <= `PNUM_GP_LAST && !pnum[0]) begin
      slot_of = `SLOT_GP_FIRST + gp_off[5:1];
    end else begin
      unique case (pnum)
        `PNUM_ABORT_TIME: slot_of = `SLOT_ABORT_TIME;
        `PNUM_STARTUP_TORQUE: slot_of = `SLOT_STARTUP_TORQUE;
        `PNUM_END_HOLD: slot_of = `SLOT_END_HOLD;
        `PNUM_REVERSAL_IDLE: slot_of = `SLOT_REVERSAL_IDLE;
        `PNUM_BRAKE_HOLD: slot_of = `SLOT_BRAKE_HOLD;
        `PNUM_VOLT_AVERAGING: slot_of = `SLOT_VOLT_AVERAGING;
        `PNUM_SUPPLY_THRESHOLD: slot_of = `SLOT_SUPPLY_THRESHOLD;
        `PNUM_TEMP_LIMIT: slot_of = `SLOT_TEMP_LIMIT;
        default: slot_of = `SLOT_NONE;
      endcase
    end
  endfunction

  function automatic logic [31:0] default_of(input logic [4:0] slot);
    unique case (slot)
      `SLOT_ABORT_TIME: default_of = `RST_ABORT_TIME;
      `SLOT_STARTUP_TORQUE: default_of = `RST_STARTUP_TORQUE;
      `SLOT_END_HOLD: default_of = `RST_END_HOLD;
      `SLOT_REVERSAL_IDLE: default_of = `RST_REVERSAL_IDLE;
      `SLOT_BRAKE_HOLD: default_of = `RST_BRAKE_HOLD;
      `SLOT_VOLT_AVERAGING: default_of = `RST_VOLT_AVERAGING;
      `SLOT_SUPPLY_THRESHOLD: default_of = `RST_SUPPLY_THRESHOLD;
      `SLOT_TEMP_LIMIT: default_of = `RST_TEMP_LIMIT;
      default: default_of = `RST_GP;
    endcase
  endfunction

  function automatic logic in_range(input logic [4:0] slot, input logic [31:0] v);
    unique case (slot)
      `SLOT_ABORT_TIME: in_range = v >= `MIN_ABORT_TIME && v <= `MAX_ABORT_TIME;
      `SLOT_STARTUP_TORQUE: in_range = v >= `MIN_STARTUP_TORQUE && v <= `MAX_STARTUP_TORQUE;
      `SLOT_END_HOLD: in_range = v >= `MIN_END_HOLD && v <= `MAX_END_HOLD;
      `SLOT_REVERSAL_IDLE: in_range = v >= `MIN_REVERSAL_IDLE && v <= `MAX_REVERSAL_IDLE;
      `SLOT_BRAKE_HOLD: in_range = v >= `MIN_BRAKE_HOLD && v <= `MAX_BRAKE_HOLD;
      `SLOT_VOLT_AVERAGING: in_range = v >= `MIN_VOLT_AVERAGING && v <= `MAX_VOLT_AVERAGING;
      `SLOT_SUPPLY_THRESHOLD: in_range = v >= `MIN_SUPPLY_THRESHOLD && v <= `MAX_SUPPLY_THRESHOLD;
      `SLOT_TEMP_LIMIT: in_range = v >= `MIN_TEMP_LIMIT && v <= `MAX_TEMP_LIMIT;
      default: in_range = 1'b1;
    endcase
  endfunction

  // live values and the image last saved by the user
  logic [31:0] param_q [`SLOT_COUNT];
  logic [31:0] param_d [`SLOT_COUNT];
  logic [31:0] saved_q [`SLOT_COUNT];
  logic [31:0] saved_d [`SLOT_COUNT];
  drive_param_pkg::cmd_state_type state_q, state_d;
  logic [15:0] status_q, status_d;
  logic boot_done_q, boot_done_d;
  logic ack_d, save_req_d, addr_clear_d, dynamic_sel_d;
  logic [15:0] ack_id_d, ack_index_d;
  logic [31:0] ack_value_d;
  logic [10:0] pnum;
  logic [3:0] req_code;
  logic [4:0] slot;
  logic resp_ok;
  logic [31:0] resp_val;

  always_comb begin
    param_d = param_q;
    saved_d = saved_q;
    state_d = state_q;
    status_d = status_q;
    boot_done_d = 1'b1;
    ack_d = 1'b0;
    ack_id_d = ack_id_word_q;
    ack_index_d = ack_index_word_q;
    ack_value_d = ack_value_word_q;
    save_req_d = 1'b0;
    addr_clear_d = 1'b0;
    dynamic_sel_d = 1'b0;
    pnum = parameter_id_word[`ID_PNUM_HI:0];
    req_code = parameter_id_word[`ID_CODE_HI:`ID_CODE_LO];
    slot = slot_of(pnum);
    resp_ok = 1'b0;
    resp_val = 32'h0000_0000;
    // boot integrity is caught on the first clock after reset release
    if (!boot_done_q) begin
      status_d = nvm_boot_corrupt ? `STAT_BUSY : `STAT_OK;
    end
    if (state_q == drive_param_pkg::CMD_SAVING) begin
      if (nvm_fail) begin
        status_d = `STAT_FAILED;
        state_d = drive_param_pkg::CMD_IDLE;
      end else if (nvm_done) begin
        status_d = `STAT_OK;
        state_d = drive_param_pkg::CMD_IDLE;
      end
    end
    // short exchange carries no parameter words at all
    if (param_if_enable && param_req_valid) begin
      ack_d = 1'b1;
      if (req_code == `REQ_READ) begin
        if (pnum == `PNUM_COMMAND) begin
          resp_ok = 1'b1;
          resp_val = {16'h0000, status_q};
        end else if (slot != `SLOT_NONE) begin
          resp_ok = 1'b1;
          resp_val = param_q[slot];
        end
      end else if (req_code == `REQ_WRITE) begin
        if (pnum == `PNUM_COMMAND) begin
          // a second command during a save would race the store
          if (standstill && state_q == drive_param_pkg::CMD_IDLE) begin
            resp_val = parameter_value_word;
            resp_ok = 1'b1;
            unique case (parameter_value_word[15:0])
              `CMD_FACTORY_SAVE: begin
                for (int i = 0; i < `SLOT_COUNT; i++) begin
                  param_d[i] = default_of(5'(i));
                  saved_d[i] = default_of(5'(i));
                end
                addr_clear_d = 1'b1;
                dynamic_sel_d = 1'b1;
                save_req_d = 1'b1;
                status_d = `STAT_BUSY;
                state_d = drive_param_pkg::CMD_SAVING;
              end
              `CMD_USER_RELOAD: begin
                for (int i = 0; i < `SLOT_COUNT; i++) begin
                  param_d[i] = saved_q[i];
                end
              end
              `CMD_FACTORY_NOSAVE: begin
                for (int i = 0; i < `SLOT_COUNT; i++) begin
                  param_d[i] = default_of(5'(i));
                end
              end
              `CMD_SAVE: begin
                for (int i = 0; i < `SLOT_COUNT; i++) begin
                  saved_d[i] = param_q[i];
                end
                save_req_d = 1'b1;
                status_d = `STAT_BUSY;
                state_d = drive_param_pkg::CMD_SAVING;
              end
              default: resp_ok = 1'b0;
            endcase
          end
        end else if (slot != `SLOT_NONE && in_range(slot, parameter_value_word)) begin
          resp_ok = 1'b1;
          resp_val = parameter_value_word;
          param_d[slot] = parameter_value_word;
        end
      end
      ack_id_d = {(resp_ok ? `RESP_OK : `RESP_ERR), 1'b0, pnum};
      ack_index_d = parameter_index_word;
      ack_value_d = resp_ok ? resp_val : param_q[slot];
      if (!resp_ok && slot == `SLOT_NONE) begin
        ack_value_d = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      for (int i = 0; i < `SLOT_COUNT; i++) begin
        param_q[i] <= default_of(5'(i));
        saved_q[i] <= default_of(5'(i));
      end
      state_q <= drive_param_pkg::CMD_IDLE;
      status_q <= `STAT_OK;
      boot_done_q <= 1'b0;
      param_ack_q <= 1'b0;
      ack_id_word_q <= 16'h0000;
      ack_index_word_q <= 16'h0000;
      ack_value_word_q <= 32'h0000_0000;
      nvm_save_req_q <= 1'b0;
      addr_clear_q <= 1'b0;
      dynamic_addr_select_q <= 1'b0;
    end else begin
      param_q <= param_d;
      saved_q <= saved_d;
      state_q <= state_d;
      status_q <= status_d;
      boot_done_q <= boot_done_d;
      param_ack_q <= ack_d;
      ack_id_word_q <= ack_id_d;
      ack_index_word_q <= ack_index_d;
      ack_value_word_q <= ack_value_d;
      nvm_save_req_q <= save_req_d;
      addr_clear_q <= addr_clear_d;
      dynamic_addr_select_q <= dynamic_sel_d;
    end
  end

  // phase timers
  logic brake_timer_on;
  logic supply_above_thr, supply_above_floor;

  ms_countdown #(.CYCLES_PER_MS(CYCLES_PER_MS)) startup_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .start(run_start),
    .period_ms(param_q[`SLOT_STARTUP_TORQUE][15:0]),
    .active_q(startup_torque_on_q)
  );

  ms_countdown #(.CYCLES_PER_MS(CYCLES_PER_MS)) end_hold_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .start(run_end),
    .period_ms(param_q[`SLOT_END_HOLD][15:0]),
    .active_q(end_hold_torque_on_q)
  );

  ms_countdown #(.CYCLES_PER_MS(CYCLES_PER_MS)) reversal_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .start(dir_reverse),
    .period_ms(param_q[`SLOT_REVERSAL_IDLE][15:0]),
    .active_q(reversal_idle_on_q)
  );

  ms_countdown #(.CYCLES_PER_MS(CYCLES_PER_MS)) brake_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .start(run_end),
    .period_ms(param_q[`SLOT_BRAKE_HOLD][15:0]),
    .active_q(brake_timer_on)
  );

  supply_averager #(.CYCLES_PER_MS(CYCLES_PER_MS)) averager (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .supply_sample(supply_sample),
    .window_ms(param_q[`SLOT_VOLT_AVERAGING][15:0]),
    .threshold(param_q[`SLOT_SUPPLY_THRESHOLD][15:0]),
    .above_threshold_q(supply_above_thr),
    .above_run_floor_q(supply_above_floor)
  );

  logic brake_d, power_d, permit_d, over_temp_d;
  logic [31:0] nvm_rd_d;

  always_comb begin
    // run_end covers the edge before the hold timer is up, no brake blip
    brake_d = run_active || run_end || brake_timer_on;
    power_d = supply_above_thr;
    // once running, the lower floor keeps the run alive
    permit_d = run_active ? supply_above_floor : supply_above_thr;
    over_temp_d = temperature_c > param_q[`SLOT_TEMP_LIMIT][15:0];
    nvm_rd_d = 32'h0000_0000;
    if (nvm_rd_slot < 5'(`SLOT_COUNT)) begin
      nvm_rd_d = saved_q[nvm_rd_slot];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      brake_released_q <= 1'b0;
      motor_power_present_q <= 1'b0;
      run_permit_q <= 1'b0;
      over_temp_q <= 1'b0;
      abort_time_ms_q <= 16'h00C8;
      nvm_rd_data_q <= 32'h0000_0000;
    end else begin
      brake_released_q <= brake_d;
      motor_power_present_q <= power_d;
      run_permit_q <= permit_d;
      over_temp_q <= over_temp_d;
      abort_time_ms_q <= param_q[`SLOT_ABORT_TIME][15:0];
      nvm_rd_data_q <= nvm_rd_d;
    end
  end

endmodule
`default_nettype wire

// [verif/drive_timing_param_store_checker.sv]
`timescale 1ns/1ps
`default_nettype none
`include "drive_param_consts.svh"

module drive_timing_param_store_checker #(
  parameter int CYCLES_PER_MS = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // exchange
  input wire logic param_if_enable,
  input wire logic param_req_valid,
  input wire logic [15:0] parameter_id_word,
  input wire logic param_ack_q,
  input wire logic [15:0] ack_id_word_q,
  // drive
  input wire logic standstill,
  input wire logic run_start,
  input wire logic run_end,
  input wire logic run_active,
  input wire logic startup_torque_on_q,
  input wire logic brake_released_q,
  input wire logic nvm_save_req_q,
  input wire logic addr_clear_q,
  input wire logic dynamic_addr_select_q
);
  logic req;
  logic cmd_wr;
  assign req = param_req_valid && param_if_enable;
  assign cmd_wr = req && parameter_id_word[`ID_CODE_HI:`ID_CODE_LO] == `REQ_WRITE
    && parameter_id_word[`ID_PNUM_HI:0] == `PNUM_COMMAND;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_ack_follows: assert property (req |=> param_ack_q)
    else $error("request not answered");
  a_ack_quiet: assert property (!req |=> !param_ack_q)
    else $error("answer without request");
  a_ack_number: assert property (req |=> ack_id_word_q[10:0] == $past(parameter_id_word[10:0]))
    else $error("answer carries wrong number");
  a_cmd_moving: assert property (cmd_wr && !standstill |=> ack_id_word_q[15:12] == `RESP_ERR)
    else $error("command taken while moving");
  a_startup_on: assert property (run_start |=> startup_torque_on_q)
    else $error("start-up torque phase missing");
  a_brake_run: assert property (run_active |=> brake_released_q)
    else $error("brake engaged during run");
  a_brake_end: assert property (run_end |=> brake_released_q)
    else $error("brake engaged at run end");
  a_save_pulse: assert property (nvm_save_req_q |=> !nvm_save_req_q)
    else $error("save request too long");
  a_save_cause: assert property (nvm_save_req_q |-> param_ack_q)
    else $error("save request without command");
  a_addr_pair: assert property (addr_clear_q |-> dynamic_addr_select_q && param_ack_q)
    else $error("address clear without dynamic select");

  c_cmd: cover property (cmd_wr);
  c_startup: cover property (run_start ##1 startup_torque_on_q [*3]);
  c_clear: cover property (addr_clear_q);
endmodule

bind drive_timing_param_store drive_timing_param_store_checker #(
  .CYCLES_PER_MS(CYCLES_PER_MS)) chk_u (.*);

`default_nettype wire

// [verif/nvm_store_model.sv]
`timescale 1ns/1ps
`default_nettype none

module nvm_store_model #(
  parameter int DELAY = 20
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // save handshake
  input wire logic save_req,
  input wire logic fail_mode,
  output logic done,
  output logic fail
);
  int cnt = 0;
  initial begin
    done = 1'b0;
    fail = 1'b0;
  end
  // save finishes well inside the scaled 200 ms allowance
  always @(posedge sys_clk) begin
    if (!rstn) begin
      cnt <= 0;
    end else if (save_req) begin
      cnt <= DELAY;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
    done <= rstn && !save_req && cnt == 1 && !fail_mode;
    fail <= rstn && !save_req && cnt == 1 && fail_mode;
  end
endmodule

`default_nettype wire

// [verif/tb_drive_timing_param_store.sv]
`timescale 1ns/1ps
`default_nettype none
`include "drive_param_consts.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
  $display("Error at %0t ns: got %0h expected %0h", $time, (a), (b)); end end

module tb_drive_timing_param_store;
  logic sys_clk = 1'b0, rstn = 1'b0, param_if_enable = 1'b1, param_req_valid = 1'b0;
  logic [15:0] parameter_id_word = 16'h0000, parameter_index_word = 16'h0000;
  logic [31:0] parameter_value_word = 32'h0000_0000;
  logic standstill = 1'b1, run_active = 1'b0, run_start = 1'b0, run_end = 1'b0;
  logic dir_reverse = 1'b0, nvm_boot_corrupt = 1'b0, fail_mode = 1'b0;
  logic [15:0] supply_sample = 16'h0000, temperature_c = 16'h0014;
  logic [4:0] nvm_rd_slot = 5'h01;
  logic param_ack_q, startup_torque_on_q, end_hold_torque_on_q, reversal_idle_on_q;
  logic brake_released_q, motor_power_present_q, run_permit_q, over_temp_q;
  logic nvm_save_req_q, addr_clear_q, dynamic_addr_select_q, nvm_done, nvm_fail;
  logic [15:0] ack_id_word_q, ack_index_word_q, abort_time_ms_q;
  logic [31:0] ack_value_word_q, nvm_rd_data_q, rv;
  logic [3:0] rc;
  int miscompares = 0, checked = 0, clears = 0, i;
  logic [10:0] pn [10] = '{`PNUM_ABORT_TIME, `PNUM_STARTUP_TORQUE, `PNUM_END_HOLD,
    `PNUM_REVERSAL_IDLE, `PNUM_BRAKE_HOLD, `PNUM_VOLT_AVERAGING, `PNUM_GP_FIRST,
    `PNUM_GP_LAST, `PNUM_SUPPLY_THRESHOLD, `PNUM_TEMP_LIMIT};
  logic [31:0] dv [10] = '{`RST_ABORT_TIME, `RST_STARTUP_TORQUE, `RST_END_HOLD,
    `RST_REVERSAL_IDLE, `RST_BRAKE_HOLD, `RST_VOLT_AVERAGING, `RST_GP, `RST_GP,
    `RST_SUPPLY_THRESHOLD, `RST_TEMP_LIMIT};

  drive_timing_param_store #(.CYCLES_PER_MS(4)) dut_u (.*);
  nvm_store_model #(.DELAY(20)) nvm_u (.sys_clk(sys_clk), .rstn(rstn),
    .save_req(nvm_save_req_q), .fail_mode(fail_mode), .done(nvm_done), .fail(nvm_fail));

  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (addr_clear_q === 1'b1 && dynamic_addr_select_q === 1'b1) clears++;

  task print_verdict;
    if (miscompares == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task xfer(input logic [3:0] code, input logic [10:0] pnum, input logic [31:0] val);
    @(negedge sys_clk);
    param_req_valid = 1'b1;
    parameter_id_word = {code, 1'b0, pnum};
    parameter_index_word = {5'h00, pnum};
    parameter_value_word = val;
    @(negedge sys_clk);
    param_req_valid = 1'b0;
    `CHK(param_ack_q, param_if_enable)
    if (param_if_enable) `CHK(ack_index_word_q, {5'h00, pnum})
    rc = ack_id_word_q[15:12];
    rv = ack_value_word_q;
  endtask

  task wr(input logic [10:0] pnum, input logic [31:0] val, input logic [3:0] code);
    xfer(`REQ_WRITE, pnum, val);
    `CHK(rc, code)
  endtask

  task rd(input logic [10:0] pnum, input logic [31:0] val);
    xfer(`REQ_READ, pnum, 32'h0000_0000);
    `CHK(rc, `RESP_OK)
    `CHK(rv, val)
  endtask

  task do_reset(input logic corrupt);
    nvm_boot_corrupt = corrupt;
    rstn = 1'b0;
    repeat (3) @(negedge sys_clk);
    rstn = 1'b1;
  endtask

  initial begin
    repeat (30000) @(posedge sys_clk);
    miscompares++;
    print_verdict;
  end

  initial begin
    do_reset(1'b1);
    xfer(`REQ_READ, `PNUM_COMMAND, 32'h0000_0000);
    `CHK(rv[15:0] != 16'h0000, 1'b1)
    do_reset(1'b0);
    rd(`PNUM_COMMAND, {16'h0000, `STAT_OK});
    for (i = 0; i < 10; i++) rd(pn[i], dv[i]);
    wr(`PNUM_ABORT_TIME, 32'h0000_0031, `RESP_ERR);
    wr(`PNUM_ABORT_TIME, 32'h0000_0032, `RESP_OK);
    @(negedge sys_clk);
    `CHK(abort_time_ms_q, 16'h0032)
    wr(`PNUM_STARTUP_TORQUE, 32'h0000_01F4, `RESP_OK);
    wr(`PNUM_STARTUP_TORQUE, 32'h0000_0009, `RESP_ERR);
    `CHK(rv, 32'h0000_01F4)
    wr(`PNUM_STARTUP_TORQUE, 32'h0000_03E9, `RESP_ERR);
    rd(`PNUM_STARTUP_TORQUE, 32'h0000_01F4);
    wr(`PNUM_REVERSAL_IDLE, 32'h0000_2710, `RESP_OK);
    wr(`PNUM_REVERSAL_IDLE, 32'h0000_2711, `RESP_ERR);
    wr(`PNUM_TEMP_LIMIT, 32'h0000_0047, `RESP_ERR);
    wr(`PNUM_GP_FIRST + 11'h002, 32'hDEAD_BEEF, `RESP_OK);
    rd(`PNUM_GP_FIRST + 11'h002, 32'hDEAD_BEEF);
    wr(11'h7FF, 32'h0000_0001, `RESP_ERR);
    param_if_enable = 1'b0;
    xfer(`REQ_READ, `PNUM_STARTUP_TORQUE, 32'h0000_0000);
    param_if_enable = 1'b1;
    wr(`PNUM_STARTUP_TORQUE, 32'h0000_000A, `RESP_OK);
    @(negedge sys_clk);
    run_start = 1'b1;
    @(negedge sys_clk);
    run_start = 1'b0;
    for (i = 0; i < 1000 && startup_torque_on_q === 1'b1; i++) @(negedge sys_clk);
    `CHK(i, 40)
    dir_reverse = 1'b1;
    @(negedge sys_clk);
    dir_reverse = 1'b0;
    @(negedge sys_clk);
    `CHK(reversal_idle_on_q, 1'b1)
    temperature_c = 16'h0047;
    repeat (2) @(negedge sys_clk);
    `CHK(over_temp_q, 1'b1)
    temperature_c = 16'h0046;
    repeat (2) @(negedge sys_clk);
    `CHK(over_temp_q, 1'b0)
    supply_sample = 16'h00C8;
    for (i = 0; i < 1200 && motor_power_present_q !== 1'b1; i++) @(negedge sys_clk);
    `CHK(motor_power_present_q, 1'b1)
    `CHK(run_permit_q, 1'b1)
    supply_sample = 16'h00B4;
    for (i = 0; i < 1200 && motor_power_present_q !== 1'b0; i++) @(negedge sys_clk);
    `CHK(i > 300, 1'b1)
    `CHK(run_permit_q, 1'b0)
    run_active = 1'b1;
    standstill = 1'b0;
    repeat (2) @(negedge sys_clk);
    `CHK(run_permit_q, 1'b1)
    wr(`PNUM_COMMAND, 32'h0000_0001, `RESP_ERR);
    run_active = 1'b0;
    standstill = 1'b1;
    run_end = 1'b1;
    @(negedge sys_clk);
    run_end = 1'b0;
    `CHK(brake_released_q, 1'b1)
    for (i = 0; i < 1000 && end_hold_torque_on_q === 1'b1; i++) @(negedge sys_clk);
    `CHK(i, 800)
    `CHK(brake_released_q, 1'b1)
    // hold of 1000 ms plus one cycle for the brake_released_q register
    for (i = 800; i < 5000 && brake_released_q === 1'b1; i++) @(negedge sys_clk);
    `CHK(i, 4001)
    wr(`PNUM_STARTUP_TORQUE, 32'h0000_012C, `RESP_OK);
    wr(`PNUM_COMMAND, {16'h0000, `CMD_SAVE}, `RESP_OK);
    rd(`PNUM_COMMAND, {16'h0000, `STAT_BUSY});
    repeat (30) @(negedge sys_clk);
    rd(`PNUM_COMMAND, {16'h0000, `STAT_OK});
    `CHK(nvm_rd_data_q, 32'h0000_012C)
    wr(`PNUM_STARTUP_TORQUE, 32'h0000_0190, `RESP_OK);
    wr(`PNUM_COMMAND, {16'h0000, `CMD_USER_RELOAD}, `RESP_OK);
    rd(`PNUM_STARTUP_TORQUE, 32'h0000_012C);
    wr(`PNUM_COMMAND, {16'h0000, `CMD_FACTORY_NOSAVE}, `RESP_OK);
    rd(`PNUM_STARTUP_TORQUE, `RST_STARTUP_TORQUE);
    `CHK(abort_time_ms_q, `RST_ABORT_TIME)
    `CHK(clears, 0)
    `CHK(nvm_rd_data_q, 32'h0000_012C)
    fail_mode = 1'b1;
    wr(`PNUM_COMMAND, {16'h0000, `CMD_SAVE}, `RESP_OK);
    repeat (30) @(negedge sys_clk);
    rd(`PNUM_COMMAND, {16'h0000, `STAT_FAILED});
    fail_mode = 1'b0;
    wr(`PNUM_STARTUP_TORQUE, 32'h0000_01F4, `RESP_OK);
    wr(`PNUM_COMMAND, {16'h0000, `CMD_FACTORY_SAVE}, `RESP_OK);
    repeat (30) @(negedge sys_clk);
    `CHK(clears, 1)
    rd(`PNUM_STARTUP_TORQUE, `RST_STARTUP_TORQUE);
    `CHK(nvm_rd_data_q, `RST_STARTUP_TORQUE)
    print_verdict;
  end
endmodule

`default_nettype wire
